// File: verilog/ccp_control_port.v
// control port slave, two-wire and four-wire
//
// What this block does
// - boots two-wire; three select low pulses enter four-wire mode
// - first byte: 7-bit device address plus direction bit
// - bytes two and three: 16-bit subaddress, high first
// - later bytes are data; word is 1, 2 or 4 bytes
// - subaddress steps per word until stop or deselect
// - reserved registers and bits read as zero
// - address is 01111 then the two strap levels
// - direction bit: one reads, zero writes
// - idle waits for start, then shifts eight bits MSB first
// - match: SDA low on ninth clock; mismatch: idle
// - stop (SDA rises, SCL high) ends every two-wire transfer
// - stop out of sequence: immediate idle; start out of sequence: address reception restarts
// - invalid subaddress: no acknowledge, idle
// - reads past the top repeat it until not-acknowledge
// - writes past the top: dropped, not acknowledged, idle
// - shared pins: clock, data/out, strap/in, strap/select
// - two-wire mode: bus slave only
// - first three four-wire writes ignored, fourth is real
// - four-wire: in on rise, out on fall; out idle undriven
// - four-wire held until powerdown pin low
// - each written byte at a valid subaddress acknowledged on ninth clock
`timescale 1ns/1ps
`default_nettype none
`include "ccp_defines.vh"

module ccp_control_port (
    input wire sys_clk,
    input wire arst_n,
    input wire powerdownPin_n,
    input wire sclSclkIn,
    input wire sdaIn,
    output wire sdaMisoOut,
    output wire sdaMisoOe,
    input wire strapHighMosiIn,
    input wire strapLowSelIn,
    output wire [15:0] memAddr,
    output wire [1:0] memByteSel,
    output wire [7:0] memWrData,
    output wire memWrEn,
    input wire [7:0] memRdData,
    input wire [7:0] memRdMask,
    output wire spiModeOut
);

    localparam ST_IDLE = 3'h0;
    localparam ST_RECV = 3'h1;
    localparam ST_ACK = 3'h2;
    localparam ST_SEND = 3'h3;
    localparam ST_MACK = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // subaddress decode
    function ccpValid;
        input [15:0] a;
        begin
            ccpValid = (a <= `CCP_PARAM_LAST) ||
                       (a >= `CCP_PROG_FIRST && a <= `CCP_PROG_LAST) ||
                       (a >= `CCP_REG_FIRST && a <= `CCP_REG_LAST);
        end
    endfunction

    function [1:0] ccpWordLast;
        input [15:0] a;
        begin
            if (a <= `CCP_PARAM_LAST)
                ccpWordLast = `CCP_LAST_PARAM;
            else if (a >= `CCP_PROG_FIRST && a <= `CCP_PROG_LAST)
                ccpWordLast = `CCP_LAST_PROG;
            else
                ccpWordLast = `CCP_LAST_REG;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // line conditioning: {select, mosi, sda, scl}
    wire [3:0] rawIn;
    reg [3:0] syncA_reg;
    reg [3:0] syncB_reg;
    reg [3:0] hist1_reg;
    reg [3:0] hist2_reg;
    reg [3:0] filt_reg;
    reg [3:0] prev_reg;
    wire [3:0] stable;

    assign rawIn = {strapLowSelIn, strapHighMosiIn, sdaIn, sclSclkIn};
    // three equal samples needed, so a glitch
    // is never an edge or a start
    assign stable = ~(syncB_reg ^ hist1_reg) & ~(hist1_reg ^ hist2_reg);

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_reg <= 4'hf;
            syncB_reg <= 4'hf;
            hist1_reg <= 4'hf;
            hist2_reg <= 4'hf;
            filt_reg <= 4'hf;
            prev_reg <= 4'hf;
        end else begin
            syncA_reg <= rawIn;
            syncB_reg <= syncA_reg;
            hist1_reg <= syncB_reg;
            hist2_reg <= hist1_reg;
            filt_reg <= (filt_reg & ~stable) | (hist2_reg & stable);
            prev_reg <= filt_reg;
        end
    end

    wire sclF = filt_reg[0];
    wire sdaF = filt_reg[1];
    wire mosiF = filt_reg[2];
    wire selF = filt_reg[3];
    wire sclRise = sclF & ~prev_reg[0];
    wire sclFall = ~sclF & prev_reg[0];
    wire selRise = selF & ~prev_reg[3];
    wire startCond = ~sdaF & prev_reg[1] & sclF & prev_reg[0];
    wire stopCond = sdaF & ~prev_reg[1] & sclF & prev_reg[0];

    ////////////////////////////////////////////////////////////////////////////
    // transfer state
    reg spiMode_reg;
    reg [1:0] selCnt_reg;
    reg [2:0] state_reg;
    reg [3:0] bitCnt_reg;
    reg [1:0] byteNum_reg;
    reg [7:0] shift_reg;
    reg [7:0] subHi_reg;
    reg [15:0] subAddr_reg;
    reg [1:0] byteInWord_reg;
    reg rw_reg;
    reg sendNext_reg;
    reg lineOut_reg;
    reg lineOe_reg;
    reg [7:0] memWrData_reg;
    reg memWrEn_reg;

    wire [7:0] rdByte = memRdData & memRdMask;
    wire [7:0] i2cByte = shift_reg;
    wire [7:0] spiByte = {shift_reg[6:0], mosiF};
    wire [15:0] i2cSub = {subHi_reg, shift_reg};
    wire [15:0] spiSub = {subHi_reg, spiByte};
    wire [6:0] myAddr = {`CCP_ADDR_UPPER, strapHighMosiIn, strapLowSelIn};
    wire addrMatch = (i2cByte[7:1] == myAddr);
    wire wordEnd = (byteInWord_reg == ccpWordLast(subAddr_reg));
    wire holdTop = rw_reg && (subAddr_reg == `CCP_SUB_HIGHEST);
    wire [15:0] subAddr_next = (wordEnd && !holdTop) ?
                               subAddr_reg + 16'h0001 : subAddr_reg;
    wire [1:0] byteInWord_next = wordEnd ? 2'h0 : byteInWord_reg + 2'h1;
    wire curValid = ccpValid(subAddr_reg);
    wire spiActive = spiMode_reg & ~selF;
    wire spiReadData = rw_reg && (byteNum_reg == `CCP_BYTE_DATA);

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            spiMode_reg <= 1'b0;
            selCnt_reg <= 2'h0;
            state_reg <= ST_IDLE;
            bitCnt_reg <= 4'h0;
            byteNum_reg <= 2'h0;
            shift_reg <= 8'h00;
            subHi_reg <= 8'h00;
            subAddr_reg <= 16'h0000;
            byteInWord_reg <= 2'h0;
            rw_reg <= 1'b0;
            sendNext_reg <= 1'b0;
            lineOut_reg <= 1'b0;
            lineOe_reg <= 1'b0;
            memWrData_reg <= 8'h00;
            memWrEn_reg <= 1'b0;
        end else begin
            memWrEn_reg <= 1'b0;
            // advance after the write pulse so the strobe sees the old address
            if (memWrEn_reg) begin
                subAddr_reg <= subAddr_next;
                byteInWord_reg <= byteInWord_next;
            end
            if (!powerdownPin_n) begin
                spiMode_reg <= 1'b0;
                selCnt_reg <= 2'h0;
                state_reg <= ST_IDLE;
                lineOe_reg <= 1'b0;
                lineOut_reg <= 1'b0;
            end else if (!spiMode_reg) begin
                // select pulses are counted once each; only the third ends two-wire traffic
                if (selRise) begin
                    if (selCnt_reg == `CCP_SEL_PULSES - 2'h1) begin
                        spiMode_reg <= 1'b1;
                        selCnt_reg <= 2'h0;
                        state_reg <= ST_IDLE;
                        lineOe_reg <= 1'b0;
                        bitCnt_reg <= 4'h0;
                        byteNum_reg <= `CCP_BYTE_ADDR;
                    end else begin
                        selCnt_reg <= selCnt_reg + 2'h1;
                    end
                end else if (stopCond) begin
                    state_reg <= ST_IDLE;
                    lineOe_reg <= 1'b0;
                end else if (startCond) begin
                    // a start anywhere restarts address reception
                    state_reg <= ST_RECV;
                    lineOe_reg <= 1'b0;
                    bitCnt_reg <= 4'h0;
                    byteNum_reg <= `CCP_BYTE_ADDR;
                end else begin
                    case (state_reg)
                        ST_IDLE: lineOe_reg <= 1'b0;
                        ST_RECV: begin
                            if (sclRise) begin
                                shift_reg <= {shift_reg[6:0], sdaF};
                                bitCnt_reg <= bitCnt_reg + 4'h1;
                            end else if (sclFall && bitCnt_reg == `CCP_BITS_PER_BYTE) begin
                                bitCnt_reg <= 4'h0;
                                case (byteNum_reg)
                                    `CCP_BYTE_ADDR: begin
                                        if (addrMatch) begin
                                            rw_reg <= i2cByte[0];
                                            sendNext_reg <= i2cByte[0];
                                            byteNum_reg <= `CCP_BYTE_SUBHI;
                                            state_reg <= ST_ACK;
                                            lineOe_reg <= 1'b1;
                                        end else begin
                                            state_reg <= ST_IDLE;
                                        end
                                    end
                                    `CCP_BYTE_SUBHI: begin
                                        subHi_reg <= i2cByte;
                                        byteNum_reg <= `CCP_BYTE_SUBLO;
                                        state_reg <= ST_ACK;
                                        lineOe_reg <= 1'b1;
                                    end
                                    `CCP_BYTE_SUBLO: begin
                                        if (ccpValid(i2cSub)) begin
                                            subAddr_reg <= i2cSub;
                                            byteInWord_reg <= 2'h0;
                                            byteNum_reg <= `CCP_BYTE_DATA;
                                            state_reg <= ST_ACK;
                                            lineOe_reg <= 1'b1;
                                        end else begin
                                            state_reg <= ST_IDLE;
                                        end
                                    end
                                    default: begin
                                        if (curValid) begin
                                            memWrData_reg <= i2cByte;
                                            memWrEn_reg <= 1'b1;
                                            state_reg <= ST_ACK;
                                            lineOe_reg <= 1'b1;
                                        end else begin
                                            state_reg <= ST_IDLE;
                                        end
                                    end
                                endcase
                            end
                        end
                        ST_ACK: begin
                            if (sclFall) begin
                                bitCnt_reg <= 4'h0;
                                if (sendNext_reg) begin
                                    shift_reg <= rdByte;
                                    lineOe_reg <= ~rdByte[7];
                                    state_reg <= ST_SEND;
                                end else begin
                                    lineOe_reg <= 1'b0;
                                    state_reg <= ST_RECV;
                                end
                            end
                        end
                        ST_SEND: begin
                            if (sclFall) begin
                                if (bitCnt_reg == `CCP_BITS_PER_BYTE - 4'h1) begin
                                    lineOe_reg <= 1'b0;
                                    state_reg <= ST_MACK;
                                end else begin
                                    shift_reg <= {shift_reg[6:0], 1'b0};
                                    lineOe_reg <= ~shift_reg[6];
                                    bitCnt_reg <= bitCnt_reg + 4'h1;
                                end
                            end
                        end
                        ST_MACK: begin
                            if (sclRise) begin
                                if (sdaF) begin
                                    state_reg <= ST_IDLE;
                                end else begin
                                    subAddr_reg <= subAddr_next;
                                    byteInWord_reg <= byteInWord_next;
                                    state_reg <= ST_ACK;
                                    sendNext_reg <= 1'b1;
                                end
                            end
                        end
                        default: state_reg <= ST_IDLE;
                    endcase
                end
            end else if (!spiActive) begin
                bitCnt_reg <= 4'h0;
                byteNum_reg <= `CCP_BYTE_ADDR;
                lineOe_reg <= 1'b0;
                lineOut_reg <= 1'b0;
            end else if (sclRise) begin
                if (!spiReadData)
                    shift_reg <= spiByte;
                if (bitCnt_reg == `CCP_BITS_PER_BYTE - 4'h1) begin
                    bitCnt_reg <= 4'h0;
                    case (byteNum_reg)
                        `CCP_BYTE_ADDR: begin
                            rw_reg <= spiByte[0];
                            byteNum_reg <= `CCP_BYTE_SUBHI;
                        end
                        `CCP_BYTE_SUBHI: begin
                            subHi_reg <= spiByte;
                            byteNum_reg <= `CCP_BYTE_SUBLO;
                        end
                        `CCP_BYTE_SUBLO: begin
                            subAddr_reg <= spiSub;
                            byteInWord_reg <= 2'h0;
                            byteNum_reg <= `CCP_BYTE_DATA;
                        end
                        default: begin
                            if (rw_reg) begin
                                subAddr_reg <= subAddr_next;
                                byteInWord_reg <= byteInWord_next;
                            end else if (curValid) begin
                                memWrData_reg <= spiByte;
                                memWrEn_reg <= 1'b1;
                            end
                        end
                    endcase
                end else begin
                    bitCnt_reg <= bitCnt_reg + 4'h1;
                end
            end else if (sclFall && spiReadData) begin
                lineOe_reg <= 1'b1;
                if (bitCnt_reg == 4'h0) begin
                    shift_reg <= rdByte;
                    lineOut_reg <= rdByte[7];
                end else begin
                    shift_reg <= {shift_reg[6:0], 1'b0};
                    lineOut_reg <= shift_reg[6];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; two-wire mode only ever pulls low, never drives high
    assign sdaMisoOut = lineOut_reg;
    assign sdaMisoOe = lineOe_reg;
    assign memAddr = subAddr_reg;
    assign memByteSel = byteInWord_reg;
    assign memWrData = memWrData_reg;
    assign memWrEn = memWrEn_reg;
    assign spiModeOut = spiMode_reg;

endmodule // ccp_control_port

`default_nettype wire

// File: verilog/ccp_defines.vh
// constants for the codec control port slave
`ifndef CCP_DEFINES_VH
`define CCP_DEFINES_VH

// fixed upper address bits
`define CCP_ADDR_UPPER 5'h0f

// byte numbers inside a transfer
`define CCP_BYTE_ADDR 2'h0
`define CCP_BYTE_SUBHI 2'h1
`define CCP_BYTE_SUBLO 2'h2
`define CCP_BYTE_DATA 2'h3

// last byte index inside a word, per region
`define CCP_LAST_REG 2'h0
`define CCP_LAST_PROG 2'h1
`define CCP_LAST_PARAM 2'h3

// subaddress map
`define CCP_PARAM_FIRST 16'h0000
`define CCP_PARAM_LAST 16'h0fff
`define CCP_PROG_FIRST 16'h1000
`define CCP_PROG_LAST 16'h1fff
`define CCP_REG_FIRST 16'hc000
`define CCP_REG_LAST 16'hc0ff
`define CCP_SUB_HIGHEST 16'hc0ff

// select pulses to enter four-wire
`define CCP_SEL_PULSES 2'h3

// bits shifted per byte
`define CCP_BITS_PER_BYTE 4'h8

`endif

// File: verification/ccp_control_port_props.sv
// checker: port timing of the control port slave
`timescale 1ns/1ps
`default_nettype none
`include "ccp_defines.vh"
module ccp_control_port_props (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic powerdownPin_n,
    input wire logic sclSclkIn,
    input wire logic sdaMisoOut,
    input wire logic sdaMisoOe,
    input wire logic strapLowSelIn,
    input wire logic [15:0] memAddr,
    input wire logic [1:0] memByteSel,
    input wire logic memWrEn,
    input wire logic spiModeOut
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    function automatic logic [1:0] lastOf(input logic [15:0] a);
        return (a <= `CCP_PARAM_LAST) ? 2'h3 : ((a <= `CCP_PROG_LAST) ? 2'h1 : 2'h0);
    endfunction
    // the highest location has no successor
    sequence wordDone;
        memWrEn && memByteSel == lastOf(memAddr) && memAddr != `CCP_SUB_HIGHEST;
    endsequence
    sequence byteDone;
        memWrEn && memByteSel != lastOf(memAddr);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property (
        $rose(arst_n) |-> !sdaMisoOe && !memWrEn && !spiModeOut && memAddr == 16'h0)
        else $error("outputs not quiet after reset");
    a_wren_pulse: assert property (memWrEn |=> !memWrEn)
        else $error("write strobe too long");
    a_word_step: assert property (
        wordDone |=> memAddr == $past(memAddr) + 16'h1 && memByteSel == 2'h0)
        else $error("no step after word");
    a_byte_step: assert property (
        byteDone |=> memAddr == $past(memAddr) && memByteSel == $past(memByteSel) + 2'h1)
        else $error("no byte step");
    a_write_mapped: assert property (
        memWrEn |-> memAddr <= `CCP_PROG_LAST
            || (memAddr >= `CCP_REG_FIRST && memAddr <= `CCP_REG_LAST))
        else $error("unmapped write");
    a_spi_sticky: assert property (spiModeOut && powerdownPin_n |=> spiModeOut)
        else $error("four-wire mode lost");
    a_pd_exit: assert property (
        $fell(powerdownPin_n) |-> ##[1:6] !spiModeOut && !sdaMisoOe)
        else $error("powerdown kept four-wire");
    a_drive_scl_low: assert property ($changed(sdaMisoOe) |-> !sclSclkIn)
        else $error("pin drive changed while clock high");
    a_shift_on_fall: assert property (
        spiModeOut && $changed(sdaMisoOut) |-> !sclSclkIn)
        else $error("serial out changed while clock high");
    a_miso_release: assert property (
        spiModeOut && $rose(strapLowSelIn) |-> ##[1:8] !sdaMisoOe)
        else $error("out driven after deselect");
    a_two_wire_out: assert property (!spiModeOut |-> !sdaMisoOut)
        else $error("two-wire value not low");
endmodule // ccp_control_port_props

bind ccp_control_port ccp_control_port_props u_props (
    .sys_clk(sys_clk), .arst_n(arst_n), .powerdownPin_n(powerdownPin_n),
    .sclSclkIn(sclSclkIn), .sdaMisoOut(sdaMisoOut), .sdaMisoOe(sdaMisoOe),
    .strapLowSelIn(strapLowSelIn), .memAddr(memAddr), .memByteSel(memByteSel),
    .memWrEn(memWrEn), .spiModeOut(spiModeOut)
);
`default_nettype wire

// File: verification/ccp_host_model.sv
// host model: two-wire and four-wire master
`timescale 1ns/1ps
`default_nettype none
module automatic ccp_host_model #(parameter int P = 10) (
    input wire logic sys_clk,
    input wire logic sdaLevel,
    output logic sclOut,
    output logic sdaLow,
    output logic mosiOut,
    output logic selOut
);
    // every phase lasts at least P clocks (deselect lasts 2 * P), above the slave's filter delay
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
        mosiOut = 1'b0;
        selOut = 1'b1;
    end
    task waitc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task setStrap(input logic hi, input logic lo);
        mosiOut <= hi;
        selOut <= lo;
    endtask
    // also the repeated start
    task start();
        sdaLow <= 1'b0;
        waitc(P);
        sclOut <= 1'b1;
        waitc(P);
        sdaLow <= 1'b1;
        waitc(P);
        sclOut <= 1'b0;
        waitc(P);
    endtask
    task stop();
        sdaLow <= 1'b1;
        waitc(P);
        sclOut <= 1'b1;
        waitc(P);
        sdaLow <= 1'b0;
        waitc(P);
    endtask
    task bitIo(input logic b, output logic r);
        sdaLow <= !b;
        waitc(P);
        sclOut <= 1'b1;
        waitc(P);
        r = sdaLevel;
        sclOut <= 1'b0;
        waitc(P);
    endtask
    task wrByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitIo(b[i], r);
        bitIo(1'b1, ack);
    endtask
    task rdByte(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, r);
            d[i] = r;
        end
        bitIo(nak, r);
    endtask
    task spiBegin();
        sclOut <= 1'b0;
        selOut <= 1'b0;
        waitc(P);
    endtask
    task spiEnd();
        selOut <= 1'b1;
        waitc(2 * P);
    endtask
    task spiByte(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            mosiOut <= b[i];
            waitc(P);
            r[i] = sdaLevel;
            sclOut <= 1'b1;
            waitc(P);
            sclOut <= 1'b0;
            waitc(P);
        end
    endtask
endmodule // ccp_host_model
`default_nettype wire

// File: verification/codec_control_port_slave_tb.sv
// testbench of the control port slave
`timescale 1ns/1ps
`default_nettype none
`include "ccp_defines.vh"
module automatic codec_control_port_slave_tb;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic powerdownPin_n = 1'b1;
    logic sclW, hostLow, mosiW, selW, ack;
    logic sdaMisoOut, sdaMisoOe, memWrEn, spiModeOut;
    logic [15:0] memAddr;
    logic [1:0] memByteSel, strap;
    logic [7:0] memWrData;
    logic [31:0] rnd = 32'h46aa;
    logic [25:0] expQ[$], gotQ[$];
    int n_errors = 0;
    int compares = 0;
    wire sdaW;
    wire [7:0] memRdData, memRdMask;
    // the shared pin has a pull-up in both modes
    assign sdaW = spiModeOut ? (sdaMisoOe ? sdaMisoOut : 1'b1) : !(hostLow | sdaMisoOe);
    assign memRdData = pat(memAddr, memByteSel);
    assign memRdMask = msk(memAddr);
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (memWrEn === 1'b1) gotQ.push_back({memAddr, memByteSel, memWrData});
    ccp_control_port dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .powerdownPin_n(powerdownPin_n),
        .sclSclkIn(sclW), .sdaIn(sdaW), .sdaMisoOut(sdaMisoOut), .sdaMisoOe(sdaMisoOe),
        .strapHighMosiIn(mosiW), .strapLowSelIn(selW), .memAddr(memAddr),
        .memByteSel(memByteSel), .memWrData(memWrData), .memWrEn(memWrEn),
        .memRdData(memRdData), .memRdMask(memRdMask), .spiModeOut(spiModeOut)
    );
    ccp_host_model host (
        .sys_clk(sys_clk), .sdaLevel(sdaW), .sclOut(sclW), .sdaLow(hostLow),
        .mosiOut(mosiW), .selOut(selW)
    );
    ////////////////////////////////////////////////////////////////////////
    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function logic [7:0] pat(input logic [15:0] a, input logic [1:0] s);
        return a[7:0] ^ a[15:8] ^ {s, 6'h2a};
    endfunction
    // c0fe reserved; bit 4 unused elsewhere
    function logic [7:0] msk(input logic [15:0] a);
        return (a == 16'hc0fe) ? 8'h00 : 8'hef;
    endfunction
    function logic mapped(input logic [15:0] a);
        return a <= 16'h1fff || (a >= 16'hc000 && a <= 16'hc0ff);
    endfunction
    task stepAddr(inout logic [15:0] a, inout logic [1:0] s, input logic hold);
        if (s != ((a <= 16'h0fff) ? 2'h3 : ((a <= 16'h1fff) ? 2'h1 : 2'h0))) s = s + 2'h1;
        else begin
            s = 2'h0;
            if (!(hold && a == 16'hc0ff)) a = a + 16'h1;
        end
    endtask
    task chkBit(input string what, input logic e, input logic g);
        chkWord(what, 26'(e), 26'(g));
    endtask
    task chkWord(input string what, input logic [25:0] e, input logic [25:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task chkWrites();
        chkWord("write count", 26'(expQ.size()), 26'(gotQ.size()));
        while (expQ.size() && gotQ.size()) chkWord("write", expQ.pop_front(), gotQ.pop_front());
        expQ.delete();
        gotQ.delete();
    endtask
    task i2cWrite(input logic [6:0] dev, input logic [15:0] sub, input int n);
        logic [15:0] a;
        logic [1:0] s;
        logic [7:0] d;
        logic hit;
        hit = (dev === {`CCP_ADDR_UPPER, strap});
        a = sub;
        s = 2'h0;
        host.start();
        host.wrByte({dev, 1'b0}, ack);
        chkBit("address ack", !hit, ack);
        if (hit) begin
            host.wrByte(sub[15:8], ack);
            host.wrByte(sub[7:0], ack);
            chkBit("subaddress ack", !mapped(sub), ack);
            for (int i = 0; i < n && ack === 1'b0; i++) begin
                rnd = lfsr(rnd);
                d = rnd[7:0] & msk(a);
                host.wrByte(d, ack);
                chkBit("data ack", !mapped(a), ack);
                if (mapped(a)) expQ.push_back({a, s, d});
                stepAddr(a, s, 1'b0);
            end
        end
        host.stop();
        chkWrites();
    endtask
    task i2cRead(input logic [15:0] sub, input int n);
        logic [15:0] a;
        logic [1:0] s;
        logic [7:0] d;
        a = sub;
        s = 2'h0;
        host.start();
        host.wrByte({`CCP_ADDR_UPPER, strap, 1'b0}, ack);
        host.wrByte(sub[15:8], ack);
        host.wrByte(sub[7:0], ack);
        host.start();
        host.wrByte({`CCP_ADDR_UPPER, strap, 1'b1}, ack);
        chkBit("read ack", 1'b0, ack);
        for (int i = 0; i < n; i++) begin
            host.rdByte(i == n - 1, d);
            chkWord("read data", {18'h0, pat(a, s) & msk(a)}, {18'h0, d});
            stepAddr(a, s, 1'b1);
        end
        host.stop();
    endtask
    task spiXfer(input logic rd, input logic [15:0] sub, input int n, input logic live);
        logic [15:0] a;
        logic [1:0] s;
        logic [7:0] d, r;
        a = sub;
        s = 2'h0;
        host.spiBegin();
        host.spiByte({7'h00, rd}, r);
        host.spiByte(sub[15:8], r);
        host.spiByte(sub[7:0], r);
        chkBit("serial out enable", rd & live, sdaMisoOe);
        for (int i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            d = rnd[7:0] & msk(a);
            host.spiByte(rd ? 8'h00 : d, r);
            if (live && rd)
                chkWord("serial read", {18'h0, pat(a, s) & msk(a)}, {18'h0, r});
            else if (live && mapped(a)) expQ.push_back({a, s, d});
            stepAddr(a, s, 1'b0);
        end
        host.spiEnd();
        chkWrites();
    endtask
    task test_done();
        if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge sys_clk);
        n_errors++;
        test_done();
    end
    initial begin
        strap = 2'h1;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        host.waitc(8);
        chkBit("mode after reset", 1'b0, spiModeOut);
        // select never rises here
        for (int k = 0; k < 4; k++) begin
            strap = {k[0], ~k[1]};
            host.setStrap(strap[1], strap[0]);
            host.waitc(10);
            i2cWrite({`CCP_ADDR_UPPER, strap}, 16'hc010 + 16'(k), 1);
        end
        i2cWrite({5'h0e, strap}, 16'hc000, 1);
        i2cWrite({`CCP_ADDR_UPPER, strap}, 16'h0fff, 8);
        i2cWrite({`CCP_ADDR_UPPER, strap}, 16'h2000, 1);
        i2cWrite({`CCP_ADDR_UPPER, strap}, 16'hc0fe, 3);
        host.start();
        host.wrByte({`CCP_ADDR_UPPER, strap, 1'b0}, ack);
        host.wrByte(8'hc0, ack);
        host.stop();
        host.wrByte(8'hda, ack);
        chkBit("ack while idle", 1'b1, ack);
        chkWrites();
        i2cRead(16'hc0fd, 4);
        i2cRead(16'h0ffe, 5);
        for (int k = 0; k < 3; k++) begin
            spiXfer(1'b0, 16'hc000, 1, 1'b0);
            chkBit("four-wire mode", k == 2, spiModeOut);
        end
        spiXfer(1'b0, 16'h1000, 3, 1'b1);
        spiXfer(1'b1, 16'hc0fe, 2, 1'b1);
        powerdownPin_n <= 1'b0;
        host.waitc(10);
        chkBit("mode after powerdown", 1'b0, spiModeOut);
        powerdownPin_n <= 1'b1;
        host.setStrap(strap[1], strap[0]);
        host.waitc(10);
        i2cWrite({`CCP_ADDR_UPPER, strap}, 16'hc020, 2);
        test_done();
    end
endmodule // codec_control_port_slave_tb
`default_nettype wire
